// ===== logic/vfcs_pkg.sv
// Contract
// - Config 0x10 bit 4 selects colour-difference mode
// - Chroma black code is mid-scale in that mode
// - Luma on green; U blue, V red full-rate
// - 0x28 bit 0: 4:2:2, blue low, red alternates
// - 0x28 bit 6 enables RGB-to-YUV conversion only
// - Luma weights 0.299, 0.587, 0.114
// - U weights -0.172, -0.339, 0.511 plus 512
// - V weights 0.511, -0.428, -0.083 plus 512
// - AC coupled by default; 0x10 bit 3 DC
// - Clamp starts at start count after sync end
// - Clamp lasts width pixels, then off till next line
// - 0x60 bit 2 zero: no clamp on coasting lines
// - Large start value puts clamp on front porch
// - Tri-level detected from digitized green samples
// - Slicer threshold is a 4-bit code
// - Threshold, hysteresis, filter from two slicer registers
// - Three sync sources, each with activity detect
// - Copy-protect mask ANDed into sync to loop
// - Mask also on sync output unless 0x7A bit 4
// - RGB in: RGB or YUV out; colour-difference in: YCbCr
package vfcs_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int ACT_WINDOW_NS = 100000;
	localparam int ACT_WINDOW_CYC = ACT_WINDOW_NS / CLK_PERIOD_NS;
	localparam int GUARD_PIX_DEF = 256;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_SYNC_SEL = 8'h02;
	localparam logic [7:0] IDX_SYNC_STATUS = 8'h03;
	localparam logic [7:0] IDX_INPUT_CFG = 8'h10;
	localparam logic [7:0] IDX_CLAMP_START_LO = 8'h24;
	localparam logic [7:0] IDX_CLAMP_START_HI = 8'h25;
	localparam logic [7:0] IDX_CLAMP_WIDTH = 8'h26;
	localparam logic [7:0] IDX_OUTPUT_FMT = 8'h28;
	localparam logic [7:0] IDX_SLICER_LEVEL = 8'h30;
	localparam logic [7:0] IDX_SLICER_SHAPE = 8'h31;
	localparam logic [7:0] IDX_CLAMP_POLICY = 8'h60;
	localparam logic [7:0] IDX_SYNC_OUT_CTRL = 8'h7a;
	// Field positions
	localparam int CFG_DC_BIT = 3;
	localparam int CFG_COLDIFF_BIT = 4;
	localparam int FMT_422_BIT = 0;
	localparam int FMT_CSC_BIT = 6;
	localparam int SHAPE_HYST_BIT = 0;
	localparam int SHAPE_LPF_BIT = 1;
	localparam int POL_COAST_CLAMP_BIT = 2;
	localparam int SOUT_MASK_DIS_BIT = 4;
	// Reset values
	localparam logic [7:0] RST_INPUT_CFG = 8'h00;
	localparam logic [15:0] RST_CLAMP_START = 16'h0010;
	localparam logic [7:0] RST_CLAMP_WIDTH = 8'h10;
	localparam logic [7:0] RST_OUTPUT_FMT = 8'h00;
	localparam logic [7:0] RST_SLICER_LEVEL = 8'h08;
	localparam logic [7:0] RST_SLICER_SHAPE = 8'h01;
	localparam logic [7:0] RST_CLAMP_POLICY = 8'h00;
	localparam logic [7:0] RST_SYNC_OUT_CTRL = 8'h00;
	// Video codes and converter weights in 1/1024 units
	localparam logic [9:0] CHROMA_BLACK = 10'h200;
	localparam logic [9:0] TRI_LEVEL_CODE = 10'h100;
	localparam logic signed [23:0] CSC_OFFSET = 24'h080000;
	localparam logic signed [23:0] K_Y_R = 24'h000132;
	localparam logic signed [23:0] K_Y_G = 24'h000259;
	localparam logic signed [23:0] K_Y_B = 24'h000075;
	localparam logic signed [23:0] K_U_R = 24'h0000b0;
	localparam logic signed [23:0] K_U_G = 24'h00015b;
	localparam logic signed [23:0] K_U_B = 24'h00020b;
	localparam logic signed [23:0] K_V_R = 24'h00020b;
	localparam logic signed [23:0] K_V_G = 24'h0001b6;
	localparam logic signed [23:0] K_V_B = 24'h000055;
	typedef enum logic [1:0] {SRC_SEPARATE, SRC_COMPOSITE_H, SRC_GREEN} vfcs_sync_src_e;
	typedef enum logic [1:0] {CL_WAIT, CL_ON, CL_DONE} vfcs_clamp_e;
endpackage

// ===== logic/vfcs_top.sv
`timescale 1ns/10ps
module vfcs_top #(
	parameter int ACT_CYCLES = vfcs_pkg::ACT_WINDOW_CYC,
	parameter int GUARD_PIX  = vfcs_pkg::GUARD_PIX_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pclk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [9:0]  adc_red,
	input  wire logic [9:0]  adc_green,
	input  wire logic [9:0]  adc_blue,
	input  wire logic        hsync_in,
	input  wire logic        vsync_in,
	input  wire logic        green_sync_input,
	input  wire logic        loop_coast,
	output logic      [9:0]  out_red,
	output logic      [9:0]  out_green,
	output logic      [9:0]  out_blue,
	output logic      [9:0]  chroma_black_code,
	output logic             clamp_out,
	output logic             dc_coupled,
	output logic             sync_to_loop,
	output logic             hsync_out,
	output logic      [3:0]  slicer_threshold,
	output logic             slicer_hyst_en,
	output logic             slicer_lpf_en
);
	import vfcs_pkg::*;

	localparam int ACW = $clog2(ACT_CYCLES + 1);

	// Elaboration check on parameters
	if (ACT_CYCLES < 2 || GUARD_PIX < 1 || GUARD_PIX > 65535) begin : g_bad
		$error("vfcs_top: bad parameter");
	end

	logic [7:0]    input_cfg_reg, clamp_width_reg, output_fmt_reg;
	logic [7:0]    slicer_level_reg, slicer_shape_reg, clamp_policy_reg, sync_out_ctrl_reg;
	logic [15:0]   clamp_start_reg;
	logic [1:0]    sync_sel_reg;
	logic [2:0]    pin_ff1, pin_ff2, pin_ff3;
	logic [ACW-1:0] act_cnt [3];
	logic [2:0]    act_flag;
	logic          sync_q, line_start, tri_line, tri_reg, cp_reg, cp_mask;
	logic          coast_line, phase_q;
	logic [15:0]   line_pix;
	logic [7:0]    clamp_left;
	vfcs_clamp_e   clamp_state;
	logic [9:0]    v_hold;
	logic          acc, wr, mapped;
	logic [7:0]    idx, rd_val;
	logic          coldiff, fmt422, csc_on, sync_raw, sync_masked;
	logic signed [23:0] rs, gs, bs, y_acc, u_acc, v_acc;
	logic [9:0]    y_c, u_c, v_c;

	// APB decode, zero wait states while the clock is enabled
	assign idx = paddr[9:2];
	assign acc = psel && penable && pclk_en;
	assign wr = acc && pwrite;
	assign pready = pclk_en;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		mapped = 1'b1;
		rd_val = 8'h00;
		case (idx)
			IDX_SYNC_SEL:       rd_val = {6'h00, sync_sel_reg};
			IDX_SYNC_STATUS:    rd_val = {3'h0, cp_reg, tri_reg, act_flag};
			IDX_INPUT_CFG:      rd_val = input_cfg_reg;
			IDX_CLAMP_START_LO: rd_val = clamp_start_reg[7:0];
			IDX_CLAMP_START_HI: rd_val = clamp_start_reg[15:8];
			IDX_CLAMP_WIDTH:    rd_val = clamp_width_reg;
			IDX_OUTPUT_FMT:     rd_val = output_fmt_reg;
			IDX_SLICER_LEVEL:   rd_val = slicer_level_reg;
			IDX_SLICER_SHAPE:   rd_val = slicer_shape_reg;
			IDX_CLAMP_POLICY:   rd_val = clamp_policy_reg;
			IDX_SYNC_OUT_CTRL:  rd_val = sync_out_ctrl_reg;
			default:            mapped = 1'b0;
		endcase
	end

	// Read data captured in the setup phase so it is a flop in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (pclk_en && psel && !penable) begin
			prdata <= {24'h000000, rd_val};
		end
	end

	// Software writable configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_cfg_reg <= RST_INPUT_CFG;
			clamp_start_reg <= RST_CLAMP_START;
			clamp_width_reg <= RST_CLAMP_WIDTH;
			output_fmt_reg <= RST_OUTPUT_FMT;
			slicer_level_reg <= RST_SLICER_LEVEL;
			slicer_shape_reg <= RST_SLICER_SHAPE;
			clamp_policy_reg <= RST_CLAMP_POLICY;
			sync_out_ctrl_reg <= RST_SYNC_OUT_CTRL;
			sync_sel_reg <= SRC_SEPARATE;
		end else if (wr) begin
			case (idx)
				IDX_SYNC_SEL:       sync_sel_reg <= pwdata[1:0];
				IDX_INPUT_CFG:      input_cfg_reg <= pwdata[7:0];
				IDX_CLAMP_START_LO: clamp_start_reg[7:0] <= pwdata[7:0];
				IDX_CLAMP_START_HI: clamp_start_reg[15:8] <= pwdata[7:0];
				IDX_CLAMP_WIDTH:    clamp_width_reg <= pwdata[7:0];
				IDX_OUTPUT_FMT:     output_fmt_reg <= pwdata[7:0];
				IDX_SLICER_LEVEL:   slicer_level_reg <= pwdata[7:0];
				IDX_SLICER_SHAPE:   slicer_shape_reg <= pwdata[7:0];
				IDX_CLAMP_POLICY:   clamp_policy_reg <= pwdata[7:0];
				IDX_SYNC_OUT_CTRL:  sync_out_ctrl_reg <= pwdata[7:0];
				default:            ;
			endcase
		end
	end

	// Mode decode
	assign coldiff = input_cfg_reg[CFG_COLDIFF_BIT];
	assign fmt422 = output_fmt_reg[FMT_422_BIT];
	assign csc_on = output_fmt_reg[FMT_CSC_BIT] && !coldiff;

	// Analog control levels out of the slicer and input configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slicer_threshold <= 4'h0;
			slicer_hyst_en <= 1'b0;
			slicer_lpf_en <= 1'b0;
			dc_coupled <= 1'b0;
			chroma_black_code <= 10'h000;
		end else if (pclk_en) begin
			slicer_threshold <= slicer_level_reg[3:0];
			slicer_hyst_en <= slicer_shape_reg[SHAPE_HYST_BIT];
			slicer_lpf_en <= slicer_shape_reg[SHAPE_LPF_BIT];
			dc_coupled <= input_cfg_reg[CFG_DC_BIT];
			chroma_black_code <= coldiff ? CHROMA_BLACK : 10'h000;
		end
	end

	// Pin synchronisers; the second stage is read, and the third is used only for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_ff1 <= 3'h0;
			pin_ff2 <= 3'h0;
			pin_ff3 <= 3'h0;
		end else if (pclk_en) begin
			pin_ff1 <= {green_sync_input, vsync_in, hsync_in};
			pin_ff2 <= pin_ff1;
			pin_ff3 <= pin_ff2;
		end
	end

	// Activity: any edge within the window keeps a source marked live
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 3; i++) begin
				act_cnt[i] <= '0;
			end
		end else if (pclk_en) begin
			for (int i = 0; i < 3; i++) begin
				if (pin_ff2[i] != pin_ff3[i]) begin
					act_cnt[i] <= ACW'(ACT_CYCLES);
				end else if (act_cnt[i] != '0) begin
					act_cnt[i] <= act_cnt[i] - 1'b1;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			act_flag[i] = (act_cnt[i] != '0);
		end
	end

	// Source select; separate and composite both ride the horizontal pin
	assign sync_raw = (sync_sel_reg == SRC_GREEN) ? pin_ff2[2] : pin_ff2[0];
	assign sync_masked = sync_raw && cp_mask;

	// Line timing from the trailing edge of the masked sync
	assign line_start = sync_q && !sync_masked;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q <= 1'b0;
			line_pix <= 16'h0000;
		end else if (pclk_en) begin
			sync_q <= sync_masked;
			if (line_start) begin
				line_pix <= 16'h0000;
			end else if (line_pix != 16'hffff) begin
				line_pix <= line_pix + 16'h0001;
			end
		end
	end

	// Copy-protect: pulses early in the line are extras, masked off
	assign cp_mask = !(cp_reg && line_pix < 16'(GUARD_PIX));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cp_reg <= 1'b0;
		end else if (pclk_en) begin
			if (sync_raw && !pin_ff3[sync_sel_reg == SRC_GREEN ? 2 : 0] && line_pix < 16'(GUARD_PIX)) begin
				cp_reg <= 1'b1;
			end else if (!act_flag[0] && !act_flag[2]) begin
				cp_reg <= 1'b0;
			end
		end
	end

	// Tri-level: green rises above blanking during the sync pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tri_line <= 1'b0;
			tri_reg <= 1'b0;
		end else if (pclk_en) begin
			if (line_start) begin
				tri_reg <= tri_line;
				tri_line <= 1'b0;
			end else if (sync_masked && adc_green > TRI_LEVEL_CODE) begin
				tri_line <= 1'b1;
			end
		end
	end

	// Coast seen on this line; a coast at the line start still counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			coast_line <= 1'b0;
		end else if (pclk_en) begin
			coast_line <= loop_coast || (coast_line && !line_start);
		end
	end

	// Clamp scheduler; start may lie past active video for front porch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clamp_state <= CL_WAIT;
			clamp_left <= 8'h00;
		end else if (pclk_en) begin
			if (line_start) begin
				clamp_state <= CL_WAIT;
			end else begin
				case (clamp_state)
					CL_WAIT: begin
						if (line_pix == clamp_start_reg) begin
							if (dc_coupled || clamp_width_reg == 8'h00 ||
								(coast_line && !clamp_policy_reg[POL_COAST_CLAMP_BIT])) begin
								clamp_state <= CL_DONE;
							end else begin
								clamp_state <= CL_ON;
								clamp_left <= clamp_width_reg;
							end
						end
					end
					CL_ON: begin
						clamp_left <= clamp_left - 8'h01;
						if (clamp_left == 8'h01 || dc_coupled) begin
							clamp_state <= CL_DONE;
						end
					end
					CL_DONE: clamp_state <= CL_DONE;
					default: clamp_state <= CL_WAIT;
				endcase
			end
		end
	end
	assign clamp_out = (clamp_state == CL_ON);

	// Sync outputs; mask removable only on the outgoing copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_to_loop <= 1'b0;
			hsync_out <= 1'b0;
		end else if (pclk_en) begin
			sync_to_loop <= sync_masked;
			hsync_out <= sync_out_ctrl_reg[SOUT_MASK_DIS_BIT] ? sync_raw : sync_masked;
		end
	end

	// Converter arithmetic, weights scaled by 1024
	function automatic logic [9:0] clip10(input logic signed [23:0] s);
		if (s < 0) begin
			return 10'h000;
		end else if (s[23:10] > 14'd1023) begin
			return 10'h3ff;
		end
		return s[19:10];
	endfunction

	assign rs = {14'h0000, adc_red};
	assign gs = {14'h0000, adc_green};
	assign bs = {14'h0000, adc_blue};
	assign y_acc = rs * K_Y_R + gs * K_Y_G + bs * K_Y_B;
	assign u_acc = CSC_OFFSET - rs * K_U_R - gs * K_U_G + bs * K_U_B;
	assign v_acc = CSC_OFFSET + rs * K_V_R - gs * K_V_G - bs * K_V_B;

	// Luma on green, U from blue path, V from red path
	always_comb begin
		if (csc_on) begin
			y_c = clip10(y_acc);
			u_c = clip10(u_acc);
			v_c = clip10(v_acc);
		end else begin
			y_c = adc_green;
			u_c = adc_blue;
			v_c = adc_red;
		end
	end

	// Pixel phase for 4:2:2, realigned to each line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= 1'b0;
			v_hold <= 10'h000;
		end else if (pclk_en) begin
			phase_q <= line_start ? 1'b0 : !phase_q;
			if (!phase_q) begin
				v_hold <= v_c;
			end
		end
	end

	// Output stage; odd-pixel chroma is dropped in 4:2:2
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_red <= 10'h000;
			out_green <= 10'h000;
			out_blue <= 10'h000;
		end else if (pclk_en) begin
			out_green <= y_c;
			if (fmt422) begin
				out_blue <= 10'h000;
				out_red <= phase_q ? v_hold : u_c;
			end else begin
				out_blue <= u_c;
				out_red <= v_c;
			end
		end
	end

	// Checks; they assume pclk_en stays high
	a_dc_no_clamp: assert property (@(posedge pclk) disable iff (!presetn)
		dc_coupled |=> !clamp_out) else $error("clamp while dc coupled");
	a_clamp_start: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(clamp_out) |-> $past(line_pix) == clamp_start_reg) else $error("clamp started off count");
	a_clamp_width: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(clamp_out) && clamp_width_reg == 8'h02 |-> clamp_out ##1 (clamp_out || $past(line_start)) ##1 !clamp_out)
		else $error("clamp width wrong");
	a_coast_block: assert property (@(posedge pclk) disable iff (!presetn)
		pclk_en && clamp_state == CL_WAIT && line_pix == clamp_start_reg && coast_line && !line_start &&
		!clamp_policy_reg[POL_COAST_CLAMP_BIT] |=> !clamp_out) else $error("clamp on coasting line");
	a_chroma_black: assert property (@(posedge pclk) disable iff (!presetn)
		pclk_en && coldiff |=> chroma_black_code == CHROMA_BLACK) else $error("chroma black not mid-scale");
	a_blue_low: assert property (@(posedge pclk) disable iff (!presetn)
		pclk_en && fmt422 |=> out_blue == 10'h000) else $error("blue not low in 4:2:2");
	a_coldiff_pass: assert property (@(posedge pclk) disable iff (!presetn)
		pclk_en && coldiff && !fmt422 |=> out_green == $past(adc_green) && out_blue == $past(adc_blue) &&
		out_red == $past(adc_red)) else $error("colour-difference data altered");
	a_even_pair: assert property (@(posedge pclk) disable iff (!presetn)
		pclk_en && coldiff && fmt422 && phase_q && $past(phase_q) == 1'b0 && $past(pclk_en)
		|=> out_red == $past(adc_red, 2)) else $error("odd pixel chroma not from even pixel");
	a_loop_mask: assert property (@(posedge pclk) disable iff (!presetn)
		pclk_en && !cp_mask |=> !sync_to_loop) else $error("masked sync reached loop");
	a_out_mask: assert property (@(posedge pclk) disable iff (!presetn)
		pclk_en && !cp_mask && !sync_out_ctrl_reg[SOUT_MASK_DIS_BIT] |=> !hsync_out) else $error("mask missing");
	a_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !mapped |-> pslverr) else $error("unmapped access not flagged");
	c_clamp: cover property (@(posedge pclk) disable iff (!presetn) $rose(clamp_out));
	c_front_porch: cover property (@(posedge pclk) disable iff (!presetn) $rose(clamp_out) && clamp_start_reg > 16'h0400);
	c_cp_seen: cover property (@(posedge pclk) disable iff (!presetn) $rose(cp_reg));
	c_tri: cover property (@(posedge pclk) disable iff (!presetn) $rose(tri_reg));
	c_csc_422: cover property (@(posedge pclk) disable iff (!presetn) csc_on && fmt422 && phase_q);
endmodule

// ===== testbench/vfcs_video_src.sv
`timescale 1ns/10ps
// Analog source model: pixel samples and the three sync pins
module vfcs_video_src (
	input  wire logic       pclk,
	output logic      [9:0] adc_red,
	output logic      [9:0] adc_green,
	output logic      [9:0] adc_blue,
	output logic            hsync_in,
	output logic            vsync_in,
	output logic            green_sync_input
);
	// Sync pins idle low outside pulses
	initial begin
		{adc_red, adc_green, adc_blue} = '0;
		{hsync_in, vsync_in, green_sync_input} = '0;
	end
	task put(input logic [9:0] r, input logic [9:0] g, input logic [9:0] b);
		adc_red   <= r;
		adc_green <= g;
		adc_blue  <= b;
	endtask
	// Pin 0 horizontal, 1 vertical, 2 embedded on green
	task drv(input int p, input logic v);
		case (p)
			0: hsync_in <= v;
			1: vsync_in <= v;
			default: green_sync_input <= v;
		endcase
	endtask
	// One line: sync pulse, optional early copy-protect pulse, then blanking
	task line(input int p, input int pw, input int len, input bit cp);
		drv(p, 1'b1);
		repeat (pw) @(posedge pclk);
		drv(p, 1'b0);
		if (cp) begin
			repeat (3) @(posedge pclk);
			drv(p, 1'b1);
			repeat (2) @(posedge pclk);
			drv(p, 1'b0);
		end
		repeat (len) @(posedge pclk);
	endtask
endmodule

// ===== testbench/vfcs_top_tb.sv
`timescale 1ns/10ps
module vfcs_top_tb;
	import vfcs_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        loop_coast = 1'b0;
	logic        pclk_en = 1'b1;
	logic [9:0]  paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic        pready, pslverr, clamp_out, dc_coupled, sync_to_loop, hsync_out;
	logic        slicer_hyst_en, slicer_lpf_en, hsync_in, vsync_in, green_sync_input;
	logic [3:0]  slicer_threshold;
	logic [9:0]  adc_red, adc_green, adc_blue, out_red, out_green, out_blue, chroma_black_code;
	logic        hs_q, cl_q, sl_q, ho_q;
	int          errors = 0, comparisons = 0, cycles = 0;
	int          ln_cnt = 0, rise_at = 0, cl_w = 0, cl_n = 0, s_n = 0, h_n = 0;

	always #2 pclk = ~pclk;

	vfcs_top #(.ACT_CYCLES(16), .GUARD_PIX(8)) uut (
		.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .adc_red(adc_red), .adc_green(adc_green), .adc_blue(adc_blue),
		.hsync_in(hsync_in), .vsync_in(vsync_in), .green_sync_input(green_sync_input),
		.loop_coast(loop_coast), .out_red(out_red), .out_green(out_green), .out_blue(out_blue),
		.chroma_black_code(chroma_black_code), .clamp_out(clamp_out), .dc_coupled(dc_coupled),
		.sync_to_loop(sync_to_loop), .hsync_out(hsync_out), .slicer_threshold(slicer_threshold),
		.slicer_hyst_en(slicer_hyst_en), .slicer_lpf_en(slicer_lpf_en)
	);
	vfcs_video_src src (
		.pclk(pclk), .adc_red(adc_red), .adc_green(adc_green), .adc_blue(adc_blue),
		.hsync_in(hsync_in), .vsync_in(vsync_in), .green_sync_input(green_sync_input)
	);

	// Position since sync fall, clamp and sync edge counters, hang guard
	always @(posedge pclk) begin
		hs_q <= hsync_in | green_sync_input;
		cl_q <= clamp_out;
		sl_q <= sync_to_loop;
		ho_q <= hsync_out;
		ln_cnt <= (hs_q && !(hsync_in | green_sync_input)) ? 1 : ln_cnt + 1;
		if (clamp_out && !cl_q) begin
			rise_at <= ln_cnt;
			cl_n <= cl_n + 1;
		end
		cl_w <= clamp_out ? (cl_q ? cl_w + 1 : 1) : cl_w;
		s_n <= s_n + int'(sync_to_loop && !sl_q);
		h_n <= h_n + int'(hsync_out && !ho_q);
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			errors++;
			end_of_test();
		end
	end

	task end_of_test;
		if (errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// Converter results allow two codes of rounding slack
	task near(input string n, input real v, input logic [9:0] g);
		int e;
		e = (v < 0.0) ? 0 : (v > 1023.0) ? 1023 : $rtoi(v + 0.5);
		comparisons++;
		if (((32'(g) + 2 >= e) && (32'(g) <= e + 2)) !== 1'b1) begin
			errors++;
			$display("Error %s expected %0d seen %0d", n, e, g);
		end
	endtask
	// One APB transfer, held until pready is seen high
	task apb(input logic [7:0] idx, input logic w, input logic [7:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(idx, 1'b1, d, r, e);
	endtask
	task rdc(input string n, input logic [7:0] idx, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(idx, 1'b0, 8'h00, r, e);
		chk(n, x, r);
	endtask
	task pix(input logic [29:0] in, input logic [29:0] x);
		@(posedge pclk);
		src.put(in[29:20], in[19:10], in[9:0]);
		repeat (2) @(posedge pclk);
		#1;
		chk("video", 32'(x), {2'b0, out_red, out_green, out_blue});
	endtask

	task t_regs;
		logic [31:0] r;
		logic        e;
		rdc("cfg", IDX_INPUT_CFG, 32'h00);
		rdc("start_lo", IDX_CLAMP_START_LO, 32'h10);
		rdc("start_hi", IDX_CLAMP_START_HI, 32'h00);
		rdc("width", IDX_CLAMP_WIDTH, 32'h10);
		rdc("fmt", IDX_OUTPUT_FMT, 32'h00);
		rdc("level", IDX_SLICER_LEVEL, 32'h08);
		rdc("shape", IDX_SLICER_SHAPE, 32'h01);
		rdc("policy", IDX_CLAMP_POLICY, 32'h00);
		rdc("sout", IDX_SYNC_OUT_CTRL, 32'h00);
		chk("dc", 32'h0, 32'(dc_coupled));
		chk("slicer", 32'h18, {26'h0, slicer_lpf_en, slicer_hyst_en, slicer_threshold});
		apb(8'h3f, 1'b0, 8'h00, r, e);
		chk("unmapped", 32'h0, r);
		chk("slverr", 32'h1, 32'(e));
	endtask
	task t_slicer;
		wr(IDX_SLICER_LEVEL, 8'h0f);
		wr(IDX_SLICER_SHAPE, 8'h02);
		repeat (2) @(posedge pclk);
		chk("slicer", 32'h2f, {26'h0, slicer_lpf_en, slicer_hyst_en, slicer_threshold});
		wr(IDX_SLICER_LEVEL, 8'h08);
		wr(IDX_SLICER_SHAPE, 8'h01);
	endtask
	task t_coldiff;
		wr(IDX_INPUT_CFG, 8'h10);
		repeat (2) @(posedge pclk);
		chk("black", 32'h200, 32'(chroma_black_code));
		pix({10'h3a1, 10'h155, 10'h0c2}, {10'h3a1, 10'h155, 10'h0c2});
		wr(IDX_OUTPUT_FMT, 8'h40);
		pix({10'h3a1, 10'h155, 10'h0c2}, {10'h3a1, 10'h155, 10'h0c2});
		wr(IDX_INPUT_CFG, 8'h00);
		wr(IDX_OUTPUT_FMT, 8'h00);
		repeat (2) @(posedge pclk);
		chk("black", 32'h0, 32'(chroma_black_code));
		pix({10'h3a1, 10'h155, 10'h0c2}, {10'h3a1, 10'h155, 10'h0c2});
	endtask
	// Clock enable low must hold the video outputs at their last value and drop pready
	task t_freeze;
		@(posedge pclk);
		pclk_en <= 1'b0;
		src.put(10'h011, 10'h022, 10'h033);
		repeat (3) @(posedge pclk);
		#1;
		chk("frozen", {2'b0, 10'h3a1, 10'h155, 10'h0c2}, {2'b0, out_red, out_green, out_blue});
		chk("pready", 32'h0, 32'(pready));
		@(posedge pclk);
		pclk_en <= 1'b1;
		pix({10'h011, 10'h022, 10'h033}, {10'h011, 10'h022, 10'h033});
	endtask
	// Parity of the first pixel is learned, then U even and V of that even pixel must alternate
	task t_422;
		int q, ph;
		wr(IDX_INPUT_CFG, 8'h10);
		wr(IDX_OUTPUT_FMT, 8'h01);
		for (int p = 0; p < 10; p++) begin
			@(posedge pclk);
			src.put(10'(10'h200 + p), 10'(10'h080 + p), 10'(10'h100 + p));
			#1;
			q = p - 1;
			if (q == 0) ph = (out_red === 10'h100) ? 0 : 1;
			if (q > 0) begin
				chk("red422", ((q + ph) % 2) ? 32'(10'h200 + q - 1) : 32'(10'h100 + q), 32'(out_red));
				chk("blue422", 32'h0, 32'(out_blue));
				chk("green422", 32'(10'h080 + q), 32'(out_green));
			end
		end
		wr(IDX_OUTPUT_FMT, 8'h00);
		wr(IDX_INPUT_CFG, 8'h00);
	endtask
	task csc_px(input int r, input int g, input int b);
		@(posedge pclk);
		src.put(10'(r), 10'(g), 10'(b));
		repeat (2) @(posedge pclk);
		#1;
		near("luma", 0.299 * r + 0.587 * g + 0.114 * b, out_green);
		near("u", -0.172 * r - 0.339 * g + 0.511 * b + 512.0, out_blue);
		near("v", 0.511 * r - 0.428 * g - 0.083 * b + 512.0, out_red);
	endtask
	task t_csc;
		wr(IDX_OUTPUT_FMT, 8'h40);
		csc_px(0, 0, 0);
		csc_px(1000, 1000, 1000);
		csc_px(1023, 0, 0);
		csc_px(0, 1023, 0);
		csc_px(0, 0, 1023);
		wr(IDX_OUTPUT_FMT, 8'h00);
	endtask
	// Clamp rises start plus four cycles after the pin falls
	task t_clamp(input int p, input logic [15:0] s, input logic [7:0] w, input int len, input int n);
		int n0;
		wr(IDX_CLAMP_START_LO, s[7:0]);
		wr(IDX_CLAMP_START_HI, s[15:8]);
		wr(IDX_CLAMP_WIDTH, w);
		n0 = cl_n;
		@(posedge pclk);
		src.line(p, 4, len, 1'b0);
		repeat (4) @(posedge pclk);
		chk("clamps", 32'(n), 32'(cl_n - n0));
		if (n > 0) begin
			chk("start", 32'(s) + 4, 32'(rise_at));
			chk("cwidth", 32'(w), 32'(cl_w));
		end
	endtask
	task t_act;
		logic [31:0] r;
		logic        e;
		for (int p = 0; p < 3; p++) begin
			repeat (40) @(posedge pclk);
			src.line(p, 2, 2, 1'b0);
			apb(IDX_SYNC_STATUS, 1'b0, 8'h00, r, e);
			chk("active", 32'(1 << p), {29'h0, r[2:0]});
		end
	endtask
	// Clamp start moved past the sync top before tri-level is judged
	task t_tri;
		logic [31:0] r;
		logic        e;
		wr(IDX_CLAMP_START_LO, 8'h31);
		wr(IDX_SYNC_SEL, 8'h02);
		src.put(10'h000, 10'h180, 10'h000);
		src.line(2, 4, 12, 1'b0);
		apb(IDX_SYNC_STATUS, 1'b0, 8'h00, r, e);
		chk("tri", 32'h1, 32'(r[3]));
		src.put(10'h000, 10'h000, 10'h000);
		src.line(2, 4, 12, 1'b0);
		apb(IDX_SYNC_STATUS, 1'b0, 8'h00, r, e);
		chk("tri", 32'h0, 32'(r[3]));
		wr(IDX_SYNC_SEL, 8'h00);
	endtask
	// Short lines keep the sync active so the detection stays armed
	task t_cp;
		int          s0, h0;
		logic [31:0] r;
		logic        e;
		src.line(0, 4, 12, 1'b1);
		s0 = s_n;
		h0 = h_n;
		src.line(0, 4, 12, 1'b1);
		chk("loop_sync", 32'd1, 32'(s_n - s0));
		chk("sync_out", 32'd1, 32'(h_n - h0));
		fork
			src.line(0, 4, 12, 1'b1);
			wr(IDX_SYNC_OUT_CTRL, 8'h10);
		join
		s0 = s_n;
		h0 = h_n;
		src.line(0, 4, 12, 1'b1);
		chk("loop_sync", 32'd1, 32'(s_n - s0));
		chk("sync_out", 32'd2, 32'(h_n - h0));
		apb(IDX_SYNC_STATUS, 1'b0, 8'h00, r, e);
		chk("cp_seen", 32'h1, 32'(r[4]));
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_slicer;
		t_coldiff;
		t_freeze;
		t_422;
		t_csc;
		t_clamp(0, 16'h0010, 8'h10, 64, 1);
		t_clamp(0, 16'h0031, 8'h03, 80, 1);
		t_clamp(0, 16'h0120, 8'h02, 320, 1);
		t_clamp(0, 16'h0010, 8'h10, 64, 1);
		wr(IDX_SYNC_SEL, 8'h02);
		t_clamp(2, 16'h0010, 8'h05, 64, 1);
		wr(IDX_SYNC_SEL, 8'h00);
		wr(IDX_INPUT_CFG, 8'h08);
		repeat (2) @(posedge pclk);
		chk("dc", 32'h1, 32'(dc_coupled));
		t_clamp(0, 16'h0010, 8'h10, 64, 0);
		wr(IDX_INPUT_CFG, 8'h00);
		loop_coast <= 1'b1;
		t_clamp(0, 16'h0010, 8'h10, 64, 0);
		wr(IDX_CLAMP_POLICY, 8'h04);
		t_clamp(0, 16'h0010, 8'h10, 64, 1);
		loop_coast <= 1'b0;
		wr(IDX_CLAMP_POLICY, 8'h00);
		t_act;
		t_tri;
		t_cp;
		end_of_test;
	end
endmodule
